// file: core/tsc_defines.vh
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH

// ---------------------------------------------
// configuration defaults
// ---------------------------------------------
`define TSC_DISCHARGE_RESET 12'h000
`define TSC_TEN_CELL_RESET 1'b0
`define TSC_CONV_ENABLE_RESET 1'b0

// ---------------------------------------------
// cell channel counts
// ---------------------------------------------
`define TSC_CELLS_FULL 4'hc
`define TSC_CELLS_TEN 4'ha

// ---------------------------------------------
// timing
// ---------------------------------------------
`define TSC_CLOCK_HZ 10000000
`define TSC_TOGGLE_HZ 1000
`define TSC_TOGGLE_HALF_CYCLES (`TSC_CLOCK_HZ / (2 * `TSC_TOGGLE_HZ))
`define TSC_CONV_CYCLES_PER_CELL 16'h1388

`endif

// file: core/tsc_sync.v
`timescale 1ns/100ps

// three-stage synchroniser; each output bit follows once its stages two and three agree
module tsc_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire i_clock,
   input wire i_resetn,
   // data
   input wire [WIDTH-1:0] i_async,
   output reg [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   // per-bit agreement, so one bit still settling never holds back the others
   wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);

   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         o_sync <= {WIDTH{1'b0}};
      end else begin
         stage1 <= i_async;
         stage2 <= stage1;
         stage3 <= stage2;
         o_sync <= (agree & stage3) | (~agree & o_sync);
      end
   end
endmodule // tsc_sync

// file: core/tsc_thermal_shutdown_control.v
`timescale 1ns/100ps
`include "tsc_defines.vh"

// Operation
// - over-temperature protection armed whenever the device is not in standby.
// - protection also armed in standby while any current-mode serial pin conducts.
// - trip above threshold restores configuration defaults: discharge off, conversions stopped.
// - trip sets a sticky thermal trip flag in the temperature group.
// - executing the read temperature group command clears the trip flag.
// - full-stack conversion covers ten or twelve channels per ten-cell select.
// - a conversion command may measure one selected cell only.
// - channels tied to the top cell input read as zero.
// - below a chain break devices keep working; polling stops above it.
// - each discharge output is a digital output with internal pull-up.
// - bottom device holds serial output low while converting, then toggles at 1kHz.
module tsc_thermal_shutdown_control #(
   parameter CELLS = 12,
   parameter TOGGLE_HALF = `TSC_TOGGLE_HALF_CYCLES,
   parameter CONV_CYCLES = `TSC_CONV_CYCLES_PER_CELL
) (
   // clock and reset
   input wire i_clock,
   input wire i_resetn,
   // analog and mode status pins
   input wire i_over_temp,
   input wire i_standby,
   input wire i_current_pin_active,
   input wire i_top_tied_valid,
   // decoded serial commands, same clock
   input wire i_write_config,
   input wire [CELLS-1:0] i_config_discharge,
   input wire i_config_ten_cell,
   input wire i_config_conv_enable,
   input wire i_start_cell_conversion_cmd,
   input wire i_single_cell,
   input wire [3:0] i_cell_select,
   input wire i_read_temperature_group_cmd,
   // chain status
   input wire i_chain_above_done,
   input wire i_chain_above_present,
   input wire i_chip_select_in,
   // outputs
   output reg [CELLS-1:0] o_discharge_drive,
   output reg o_ten_cell_select,
   output reg o_thermal_trip_flag,
   output reg o_protect_armed,
   output reg o_converting,
   output reg [3:0] o_channel,
   output reg o_channel_zero,
   output reg o_serial_data_out,
   output reg o_serial_data_out_oen
);
   // ---------------------------------------------
   // pin synchronisation
   // ---------------------------------------------
   // standby and pin status are slow levels, so four clocks of latency cost nothing
   wire [2:0] sync_out;
   wire over_temp = sync_out[0];
   wire standby = sync_out[1];
   wire current_pin = sync_out[2];

   tsc_sync #(
      .WIDTH(3)
   ) u_sync (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_async({i_current_pin_active, i_standby, i_over_temp}),
      .o_sync(sync_out)
   );

   // ---------------------------------------------
   // protection
   // ---------------------------------------------
   // only synchronised pins feed the trip; a raw pin could reset half the config
   wire armed = !standby || current_pin;
   wire trip = armed && over_temp;

   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_protect_armed <= 1'b0;
         o_thermal_trip_flag <= 1'b0;
      end else begin
         o_protect_armed <= armed;
         // set wins over a clear in the same cycle
         if (trip) begin
            o_thermal_trip_flag <= 1'b1;
         end else if (i_read_temperature_group_cmd) begin
            o_thermal_trip_flag <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // configuration
   // ---------------------------------------------
   reg conv_enable;

   // serial commands are still accepted after a trip, only the config is forced
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_discharge_drive <= {CELLS{1'b0}};
         o_ten_cell_select <= `TSC_TEN_CELL_RESET;
         conv_enable <= `TSC_CONV_ENABLE_RESET;
      end else if (trip) begin
         // a trip outranks a write landing in the same cycle
         o_discharge_drive <= {CELLS{1'b0}};
         o_ten_cell_select <= `TSC_TEN_CELL_RESET;
         conv_enable <= `TSC_CONV_ENABLE_RESET;
      end else if (i_write_config) begin
         o_discharge_drive <= i_config_discharge;
         o_ten_cell_select <= i_config_ten_cell;
         conv_enable <= i_config_conv_enable;
      end
   end

   // ---------------------------------------------
   // conversion sequencer
   // ---------------------------------------------
   // idle: waiting for a start; conv: stepping channels; wait: own scan done,
   // devices above still busy; toggle: every device done, poll output toggles
   localparam ST_IDLE = 2'b00;
   localparam ST_CONV = 2'b01;
   localparam ST_WAIT = 2'b10;
   localparam ST_TOGGLE = 2'b11;

   reg [1:0] state;
   reg [3:0] last_channel;
   reg [15:0] conv_count;
   reg [15:0] tog_count;
   reg [3:0] next_channel;

   // ---------------------------------------------
   // conversion timing
   // ---------------------------------------------
   // counters stop one short of their length, so a count of n spans n clocks
   wire conv_tick = (conv_count == CONV_CYCLES[15:0] - 16'h0001);
   wire tog_tick = (tog_count == TOGGLE_HALF[15:0] - 16'h0001);
   wire on_last_channel = (o_channel == last_channel);
   // nothing reachable above: only this device's own scan is waited for
   wire chain_done = i_chain_above_done || !i_chain_above_present;
   // scan length is fixed at the start; a later write does not stretch a running scan
   wire [3:0] stack_last = (o_ten_cell_select ? `TSC_CELLS_TEN : `TSC_CELLS_FULL) - 4'h1;

   always @* begin
      next_channel = o_channel + 4'h1;
   end

   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= ST_IDLE;
         o_converting <= 1'b0;
         o_channel <= 4'h0;
         last_channel <= 4'h0;
         conv_count <= 16'h0000;
         tog_count <= 16'h0000;
         o_channel_zero <= 1'b0;
         o_serial_data_out <= 1'b1;
         o_serial_data_out_oen <= 1'b1;
      end else begin
         o_channel_zero <= o_converting && i_top_tied_valid;
         if (trip) begin
            // a trip abandons the scan; the channel in flight is lost
            state <= ST_IDLE;
            o_converting <= 1'b0;
            o_serial_data_out_oen <= 1'b1;
            o_serial_data_out <= 1'b1;
         end else if (i_chip_select_in && state != ST_CONV) begin
            // chip select cannot cut a scan short, only end the polling after it
            state <= ST_IDLE;
            o_serial_data_out_oen <= 1'b1;
            o_serial_data_out <= 1'b1;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (i_start_cell_conversion_cmd && conv_enable) begin
                     state <= ST_CONV;
                     o_converting <= 1'b1;
                     conv_count <= 16'h0000;
                     if (i_single_cell) begin
                        o_channel <= i_cell_select;
                        last_channel <= i_cell_select;
                     end else begin
                        o_channel <= 4'h0;
                        last_channel <= stack_last;
                     end
                     o_serial_data_out <= 1'b0;
                     o_serial_data_out_oen <= 1'b0;
                  end
               end
               ST_CONV: begin
                  if (conv_tick) begin
                     conv_count <= 16'h0000;
                     if (on_last_channel) begin
                        o_converting <= 1'b0;
                        state <= ST_WAIT;
                     end else begin
                        o_channel <= next_channel;
                     end
                  end else begin
                     conv_count <= conv_count + 16'h0001;
                  end
               end
               ST_WAIT: begin
                  if (chain_done) begin
                     state <= ST_TOGGLE;
                     tog_count <= 16'h0000;
                  end
               end
               default: begin
                  // first toggle comes one half period after the chain reports done
                  if (tog_tick) begin
                     tog_count <= 16'h0000;
                     o_serial_data_out <= !o_serial_data_out;
                  end else begin
                     tog_count <= tog_count + 16'h0001;
                  end
               end
            endcase
         end
      end
   end
endmodule // tsc_thermal_shutdown_control

// file: tb/thermal_shutdown_control_test.sv
`timescale 1ns/100ps
module thermal_shutdown_control_test;
// ----
// bench
// ----
logic clk = 0, rstn = 0, ot = 0, sb = 0, cp = 0, tt = 0, wr = 0, ten = 0, ce = 0, st = 0, sc = 0, rd = 0, cs = 0;
logic brk = 0;
logic [11:0] dis = 0;
logic [3:0] sel = 0;
wire dn, pr, tcs, flg, arm, cnv, chz, serial_data_out, oen;
wire [11:0] drv;
wire [3:0] chn;
int bad_count = 0, checked = 0;
initial forever #50 clk = ~clk;
tsc_thermal_shutdown_control #(.TOGGLE_HALF(4), .CONV_CYCLES(3)) uut (.i_clock(clk), .i_resetn(rstn),
   .i_over_temp(ot), .i_standby(sb), .i_current_pin_active(cp), .i_top_tied_valid(tt), .i_write_config(wr),
   .i_config_discharge(dis), .i_config_ten_cell(ten), .i_config_conv_enable(ce), .i_single_cell(sc),
   .i_start_cell_conversion_cmd(st), .i_cell_select(sel), .i_read_temperature_group_cmd(rd),
   .i_chain_above_done(dn), .i_chain_above_present(pr), .i_chip_select_in(cs), .o_discharge_drive(drv),
   .o_ten_cell_select(tcs), .o_thermal_trip_flag(flg), .o_protect_armed(arm), .o_converting(cnv),
   .o_channel(chn), .o_channel_zero(chz), .o_serial_data_out(serial_data_out), .o_serial_data_out_oen(oen));
tsc_chain_model #(.DLY(45)) far (.i_clock(clk), .i_converting(cnv), .i_broken(brk), .o_done(dn), .o_present(pr));
task cyc(input int n);
   repeat (n) @(posedge clk);
   #10;
endtask
task chk(input string nm, input logic [11:0] e, g);
   checked++;
   if (e !== g) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
   end
endtask
task test_done;
   $display("checked %0d bad_count %0d", checked, bad_count);
   if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
   else
      $display("Finished with errors");
   $finish;
endtask
task lim(input int k);
   if (k >= 300) begin
      bad_count++;
      test_done;
   end
endtask
task wcfg(input logic [11:0] d, input logic t, c);
   wr = 1; dis = d; ten = t; ce = c;
   cyc(1);
   wr = 0;
endtask
task conv(input logic s, input logic [3:0] c, input int n);
   int k;
   k = 0;
   sc = s; sel = c; tt = 1; st = 1;
   cyc(1);
   st = 0;
   if (s) chk("channel", {8'h00, c}, {8'h00, chn});
   while (cnv === 1'b1 && k < 300) begin
      k++;
      cyc(1);
   end
   lim(k);
   tt = 0;
   chk("cycles", 12'(n * 3), 12'(k));
   k = 0;
   while (serial_data_out !== 1'b1 && k < 300) begin
      k++;
      cyc(1);
   end
   lim(k);
   cyc(3);
   chk("toggle", 12'h0002, {10'h000, serial_data_out, oen});
   cyc(1);
   chk("toggle", 12'h0000, {10'h000, serial_data_out, oen});
   cs = 1;
   cyc(1);
   cs = 0;
   chk("release", 12'h0003, {10'h000, serial_data_out, oen});
   $display("conversion of %0d end", n);
endtask
task t_trip;
   wcfg(12'h0a5a, 1, 1);
   chk("drive", 12'h0a5a, drv);
   chk("armed", 12'h0001, {11'h000, arm});
   st = 1;
   cyc(1);
   st = 0;
   cs = 1;
   cyc(1);
   cs = 0;
   ot = 1;
   chk("cs ignored", 12'h0001, {9'h000, serial_data_out, oen, cnv});
   cyc(7);
   chk("tripped", 12'h0001, {11'h000, flg});
   chk("defaults", 12'h0000, drv | {11'h000, tcs});
   chk("stopped", 12'h0006, {9'h000, serial_data_out, oen, cnv});
   rd = 1;
   cyc(1);
   rd = 0; ot = 0;
   chk("set wins", 12'h0001, {11'h000, flg});
   cyc(6);
   st = 1;
   cyc(1);
   st = 0; rd = 1;
   chk("no start", 12'h0000, {11'h000, cnv});
   cyc(1);
   rd = 0;
   chk("cleared", 12'h0000, {11'h000, flg});
   wcfg(12'h0fff, 0, 1);
   chk("reconfig", 12'h0fff, drv);
   $display("trip end");
endtask
task t_standby;
   sb = 1; ot = 1;
   cyc(8);
   chk("asleep", 12'h0000, {10'h000, arm, flg});
   cp = 1;
   cyc(8);
   chk("pin trip", 12'h0003, {10'h000, arm, flg});
   ot = 0; cp = 0;
   cyc(8);
   rd = 1;
   cyc(1);
   rd = 0; sb = 0;
   chk("cleared", 12'h0000, {11'h000, flg});
   $display("standby end");
endtask
task t_cells;
   wcfg(12'h0003, 1, 1);
   conv(0, 4'h0, 10);
   wcfg(12'h0003, 0, 1);
   conv(0, 4'h0, 12);
endtask
task t_single;
   conv(1, 4'h5, 1);
endtask
task t_broken;
   brk = 1;
   conv(0, 4'h0, 12);
   brk = 0;
endtask
initial begin
   cyc(4);
   rstn = 1;
   t_cells;
   t_single;
   t_broken;
   t_trip;
   t_standby;
   test_done;
end
endmodule // thermal_shutdown_control_test

// file: tb/tsc_assertions.sv
`timescale 1ns/100ps
// ----
// port checks
// ----
module tsc_assertions #(parameter CELLS = 12) (
   input wire logic i_clock, i_resetn, i_over_temp, i_standby, i_current_pin_active, i_top_tied_valid,
   input wire logic i_write_config, i_config_ten_cell, i_read_temperature_group_cmd, o_ten_cell_select,
   input wire logic o_thermal_trip_flag, o_protect_armed, o_converting, o_channel_zero, o_serial_data_out,
   input wire logic o_serial_data_out_oen,
   input wire logic [CELLS-1:0] i_config_discharge, o_discharge_drive
);
default clocking @(posedge i_clock); endclocking
default disable iff (!i_resetn);
// seven cycles leaves room for the three-flop pin synchroniser
a_armed_awake: assert property ((!i_standby)[*7] |-> o_protect_armed)
   else $error("unarmed while awake");
a_armed_asleep: assert property ((i_standby && !i_current_pin_active)[*7] |-> !o_protect_armed)
   else $error("armed in standby");
a_trip_resets: assert property ((o_protect_armed && i_over_temp)[*7] |->
   o_thermal_trip_flag && o_discharge_drive == 0 && !o_ten_cell_select) else $error("no trip");
a_flag_holds: assert property (o_thermal_trip_flag && !i_read_temperature_group_cmd |=> o_thermal_trip_flag)
   else $error("flag lost");
a_flag_clears: assert property ((!i_over_temp)[*6] ##0 i_read_temperature_group_cmd |=> !o_thermal_trip_flag)
   else $error("flag kept");
a_write_loads: assert property ((!i_over_temp)[*6] ##0 i_write_config |=>
   o_discharge_drive == $past(i_config_discharge) && o_ten_cell_select == $past(i_config_ten_cell))
   else $error("config not loaded");
a_trip_stops: assert property ($rose(o_thermal_trip_flag) |-> !o_converting && o_serial_data_out_oen)
   else $error("scan survived trip");
a_poll_low: assert property (o_converting |-> !o_serial_data_out && !o_serial_data_out_oen)
   else $error("output not low");
a_zero_flag: assert property (##1 o_channel_zero == ($past(o_converting) && $past(i_top_tied_valid)))
   else $error("zero flag wrong");
endmodule // tsc_assertions
bind tsc_thermal_shutdown_control tsc_assertions #(.CELLS(CELLS)) checks (
   .i_clock(i_clock),
   .i_resetn(i_resetn),
   .i_over_temp(i_over_temp),
   .i_standby(i_standby),
   .i_current_pin_active(i_current_pin_active),
   .i_top_tied_valid(i_top_tied_valid),
   .i_write_config(i_write_config),
   .i_config_ten_cell(i_config_ten_cell),
   .i_read_temperature_group_cmd(i_read_temperature_group_cmd),
   .o_ten_cell_select(o_ten_cell_select),
   .o_thermal_trip_flag(o_thermal_trip_flag),
   .o_protect_armed(o_protect_armed),
   .o_converting(o_converting),
   .o_channel_zero(o_channel_zero),
   .o_serial_data_out(o_serial_data_out),
   .o_serial_data_out_oen(o_serial_data_out_oen),
   .i_config_discharge(i_config_discharge),
   .o_discharge_drive(o_discharge_drive)
);

// file: tb/tsc_chain_model.sv
`timescale 1ns/100ps
// ----
// devices above in the chain
// ----
module tsc_chain_model #(parameter DLY = 45) (
   input wire logic i_clock, i_converting, i_broken,
   output logic o_done, o_present
);
logic c1 = 0;
int n = 0;
always @(posedge i_clock) begin
   c1 <= i_converting;
   n <= (i_converting && !c1) ? 0 : n + 1;
end
// upper devices finish later than the bottom one; a cut link leaves done wandering
assign o_present = !i_broken;
assign o_done = i_broken ? n[0] : n >= DLY;
endmodule // tsc_chain_model
